/* flame_detector_supervisor.sv */
// Flame detector supervisor: alarm confirmation, faults, window check, self-test, outputs
// Summary of operation
// R01: Non-latching faults follow cause; latching hold until reset
// R02: Obscured window is hardware-class, hardware flash pattern
// R03: Config fault on download error or heater without aux
// R04: Service mode: no detection, both LEDs flash per 5s
// R05: Fault relay opens for hardware, window, cleanliness faults
// R06: Loop 0 mA hardware/window, 2 mA cleanliness fault
// R07: Addressable loop: hardware at most 10, dirty 11-51
// R08: Separate status bits: hardware, obscured, dirty
// R09: Sample once per second, alarm when window count met
// R10: Confirmation settings 3of5, 6of8, 12of14
// R11: Continuous loop mode: no confirmation, sensor drives loop
// R12: Non-latching alarm clears after ten clean samples
// R13: Latched alarms/faults reset by wire, network, tool
// R14: Reset blanks outputs, re-asserts, reruns window check
// R15: Manual check: single, immediate; ignored during alarm/test
// R16: Automatic check every interval, first after one interval
// R17: Postpone auto check in alarm; manual ignored in alarm
// R18: Twenty successive dirty automatic checks give fault
// R19: Obscured: five-minute interval, five more give fault
// R20: Window faults clear only on clean rerun
// R21: Self-test flashes lamp, detection reported as alarm
// R22: Video overlay alarm and typed fault, configurable
// R23: Hardware plus dirty: loops show hardware value
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module flame_detector_supervisor #(
    parameter int TICK_CYCLES = fds_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic candidate_alarm_i,
    input wire logic pre_alarm_i,
    input wire logic [7:0] sensor_level_i,
    input wire logic hw_fault_i,
    input wire logic service_mode_i,
    input wire logic wired_reset_i,
    input wire logic tool_reset_i,
    input wire logic manual_check_i,
    input wire logic self_test_req_i,
    input wire logic window_result_valid_i,
    input wire logic [1:0] window_result_i,
    output logic window_check_start_o,
    output logic test_lamp_o,
    output logic alarm_led_o,
    output logic fault_led_o,
    output logic alarm_relay_o,
    output logic fault_relay_open_o,
    output logic [7:0] loop_ma_x10_o,
    output logic [7:0] addr_loop_o,
    output logic overlay_alarm_o,
    output logic overlay_fault_o,
    output logic [2:0] overlay_fault_type_o
);
    // ==========================================================
    // Register bus
    logic [8:0] ctrl_reg;
    logic [7:0] interval_reg;
    logic [7:0] aw_addr_reg;
    logic aw_got_reg, w_got_reg;
    logic [31:0] w_data_reg;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire [7:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_reg;
    wire [31:0] wr_data = w_take ? s_axi_wdata : w_data_reg;
    wire wr_fire = (aw_got_reg | aw_take) & (w_got_reg | w_take) & ~s_axi_bvalid;
    wire wr_ctrl = wr_fire & (wr_addr == fds_pkg::OFS_CTRL);
    wire wr_cmd = wr_fire & (wr_addr == fds_pkg::OFS_CMD);
    wire wr_int = wr_fire & (wr_addr == fds_pkg::OFS_INTERVAL);
    wire wr_ok = wr_ctrl | wr_cmd | wr_int;
    wire rd_take = s_axi_arvalid & s_axi_arready;
    // Write channels taken in either order; both held until response drains
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (aw_take) aw_addr_reg <= s_axi_awaddr;
            if (w_take) w_data_reg <= s_axi_wdata;
            aw_got_reg <= wr_fire ? 1'b0 : (aw_got_reg | aw_take);
            w_got_reg <= wr_fire ? 1'b0 : (w_got_reg | w_take);
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;

    // Configuration registers; byte 0 and byte 1 strobes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= fds_pkg::CTRL_RESET;
            interval_reg <= fds_pkg::INTERVAL_RESET;
        end else begin
            if (wr_ctrl & s_axi_wstrb[0]) ctrl_reg[7:0] <= wr_data[7:0];
            if (wr_ctrl & s_axi_wstrb[1]) ctrl_reg[8] <= wr_data[8];
            if (wr_int & s_axi_wstrb[0] & (wr_data[7:0] != 8'h00)) interval_reg <= wr_data[7:0];
        end
    end
    wire latching = ctrl_reg[fds_pkg::CTRL_LATCH];
    wire [1:0] conf_sel = ctrl_reg[fds_pkg::CTRL_CONF +: 2];
    wire auto_mode = ctrl_reg[fds_pkg::CTRL_AUTO];
    wire cont_mode = ctrl_reg[fds_pkg::CTRL_CONT];
    wire cmd_ok = wr_cmd & s_axi_wstrb[0];

    // ==========================================================
    // Event sources and one-second divider
    wire any_reset = wired_reset_i | tool_reset_i | (cmd_ok & wr_data[fds_pkg::CMD_RESET]); // R13
    wire test_req = self_test_req_i | (cmd_ok & wr_data[fds_pkg::CMD_TEST]); // R21
    wire man_req = manual_check_i | (cmd_ok & wr_data[fds_pkg::CMD_CHECK]);
    logic [31:0] div_reg;
    logic tick_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == 32'(TICK_CYCLES - 1));
            div_reg <= (div_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Alarm confirmation
    logic [13:0] hist_reg;
    logic alarm_reg, test_reg;
    logic [3:0] clear_reg, test_sec_reg;
    function automatic logic [3:0] ones(input logic [13:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 14; i++) n = n + {3'h0, v[i]};
        return n;
    endfunction
    // Window length and threshold per switch setting
    wire [13:0] win_mask = (conf_sel == 2'h0) ? 14'h001F : (conf_sel == 2'h1) ? 14'h00FF : 14'h3FFF; // R10
    wire [3:0] need = (conf_sel == 2'h0) ? 4'h3 : (conf_sel == 2'h1) ? 4'h6 : 4'hC; // R10
    wire sample = candidate_alarm_i & ~service_mode_i; // R04
    wire [13:0] hist_next = {hist_reg[12:0], sample}; // R09
    wire confirmed = ones(hist_next & win_mask) >= need; // R09
    wire busy_block = alarm_reg | pre_alarm_i | test_reg; // R15 R17
    // Alarm state updates on the second tick; reset drops it and lets live cause rebuild it
    always_ff @(posedge clk_i) begin
        if (rst_i | any_reset | service_mode_i) begin // R14 R04
            hist_reg <= 14'h0000;
            alarm_reg <= 1'b0;
            clear_reg <= 4'h0;
        end else if (tick_reg) begin
            hist_reg <= hist_next;
            if (cont_mode) begin
                alarm_reg <= sample; // R11
            end else if (confirmed) begin
                alarm_reg <= 1'b1;
                clear_reg <= 4'h0;
            end else if (alarm_reg & ~latching) begin // R13
                clear_reg <= clear_reg + 4'h1;
                if (clear_reg == fds_pkg::CLEAR_RUN - 4'h1) alarm_reg <= 1'b0; // R12
            end
        end
    end

    // Alarm self-test: lamp runs for fourteen seconds, the longest confirmation window, whatever the setting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_reg <= 1'b0;
            test_sec_reg <= 4'h0;
        end else if (test_req & ~test_reg & ~service_mode_i) begin
            test_reg <= 1'b1; // R21
            test_sec_reg <= 4'h0;
        end else if (test_reg & tick_reg) begin
            test_sec_reg <= test_sec_reg + 4'h1;
            if (test_sec_reg == fds_pkg::TEST_SEC - 4'h1) test_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Window cleanliness check scheduling and evaluation
    fds_pkg::wc_state_t wc_state_reg;
    logic wc_manual_reg, obsc_mode_reg, win_dirty_reg, win_obsc_reg, start_reg;
    logic [15:0] sec_cnt_reg;
    logic [4:0] dirty_run_reg, obsc_run_reg;
    wire [7:0] period_min = obsc_mode_reg ? fds_pkg::OBSC_MIN : interval_reg; // R19
    wire [15:0] period_sec = 16'(period_min * fds_pkg::SEC_PER_MIN);
    wire due = auto_mode & (sec_cnt_reg >= period_sec); // R16
    wire wc_idle = (wc_state_reg == fds_pkg::WC_IDLE);
    wire man_go = man_req & ~busy_block & wc_idle; // R15
    wire auto_go = due & ~busy_block & wc_idle & ~man_go; // R17
    wire rerun_go = any_reset & (win_dirty_reg | win_obsc_reg) & wc_idle; // R14
    wire done = (wc_state_reg == fds_pkg::WC_BUSY) & window_result_valid_i;
    wire res_clean = window_result_i == fds_pkg::WIN_CLEAN;
    wire res_dirty = window_result_i == fds_pkg::WIN_DIRTY;
    wire res_obsc = window_result_i == fds_pkg::WIN_OBSC;
    wire [4:0] dirty_inc = dirty_run_reg + 5'h01;
    wire [4:0] obsc_inc = obsc_run_reg + 5'h01;
    // Interval counter restarts at every check so the first runs one interval after power-up
    always_ff @(posedge clk_i) begin
        if (rst_i | auto_go | man_go | rerun_go) sec_cnt_reg <= 16'h0000; // R16
        else if (tick_reg & ~due) sec_cnt_reg <= sec_cnt_reg + 16'h0001;
    end
    // Sequencer: one start pulse, then wait for the result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wc_state_reg <= fds_pkg::WC_IDLE;
            wc_manual_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= man_go | auto_go | rerun_go;
            case (wc_state_reg)
                fds_pkg::WC_IDLE: begin
                    if (man_go | auto_go | rerun_go) begin
                        wc_state_reg <= fds_pkg::WC_BUSY;
                        wc_manual_reg <= man_go | rerun_go;
                    end
                end
                fds_pkg::WC_BUSY: begin
                    if (window_result_valid_i) wc_state_reg <= fds_pkg::WC_IDLE;
                end
                default: wc_state_reg <= fds_pkg::WC_IDLE;
            endcase
        end
    end
    // Manual results report at once; automatic ones accumulate successive runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_dirty_reg <= 1'b0;
            win_obsc_reg <= 1'b0;
            obsc_mode_reg <= 1'b0;
            dirty_run_reg <= 5'h00;
            obsc_run_reg <= 5'h00;
        end else if (done) begin
            if (res_clean) begin
                win_dirty_reg <= 1'b0; // R20
                win_obsc_reg <= 1'b0; // R20
                obsc_mode_reg <= 1'b0;
                dirty_run_reg <= 5'h00;
                obsc_run_reg <= 5'h00;
            end else if (wc_manual_reg) begin
                win_dirty_reg <= res_dirty; // R15
                win_obsc_reg <= res_obsc; // R15
            end else if (res_dirty) begin
                obsc_mode_reg <= 1'b0;
                obsc_run_reg <= 5'h00;
                dirty_run_reg <= dirty_inc;
                if (dirty_inc >= fds_pkg::DIRTY_RUN) win_dirty_reg <= 1'b1; // R18
            end else if (res_obsc) begin
                obsc_mode_reg <= 1'b1; // R19
                obsc_run_reg <= obsc_mode_reg ? obsc_inc : 5'h00;
                if (obsc_mode_reg & (obsc_inc >= fds_pkg::OBSC_RUN)) win_obsc_reg <= 1'b1; // R19
            end
        end
    end

    // ==========================================================
    // Fault classes
    logic hw_latch_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i | any_reset) hw_latch_reg <= 1'b0; // R13
        else hw_latch_reg <= latching & (hw_latch_reg | hw_fault_i); // R01
    end
    wire hw_fault = hw_fault_i | hw_latch_reg; // R01
    wire hw_class = hw_fault | win_obsc_reg; // R02
    wire cfg_fault = ctrl_reg[fds_pkg::CTRL_CFGERR]
        | (ctrl_reg[fds_pkg::CTRL_HEAT] & ~ctrl_reg[fds_pkg::CTRL_AUX]); // R03
    wire alarm_out = alarm_reg | (cont_mode & test_reg & sample);
    logic [2:0] sec5_reg;
    // Five-second phase for the service flash
    always_ff @(posedge clk_i) begin
        if (rst_i) sec5_reg <= 3'h0;
        else if (tick_reg) sec5_reg <= (sec5_reg == fds_pkg::SERVICE_SEC - 3'h1) ? 3'h0 : sec5_reg + 3'h1;
    end
    // Hardware pattern: seconds 1 and 3 of each five; dirty pattern: one second in five
    wire hw_flash = hw_class & sec5_reg[0];
    wire dirty_flash = win_dirty_reg & (sec5_reg == 3'h0);
    wire srv_flash = service_mode_i & (sec5_reg == 3'h0); // R04
    wire [7:0] loop_ma = hw_class ? fds_pkg::MA_HW // R06 R23
        : win_dirty_reg ? fds_pkg::MA_DIRTY // R06
        : cont_mode ? sensor_level_i // R11
        : alarm_out ? fds_pkg::MA_ALARM
        : pre_alarm_i ? fds_pkg::MA_PRE : fds_pkg::MA_NORMAL;
    wire [7:0] addr_val = hw_class ? fds_pkg::AL_HW // R07 R23
        : win_dirty_reg ? fds_pkg::AL_DIRTY // R07
        : alarm_out ? fds_pkg::AL_ALARM
        : pre_alarm_i ? fds_pkg::AL_PRE : fds_pkg::AL_NORMAL;
    wire [8:0] status = {~wc_idle, test_reg, service_mode_i, cfg_fault, win_dirty_reg,
        win_obsc_reg, hw_fault, pre_alarm_i, alarm_out}; // R08

    // Output flops; a reset cycle blanks every indicator before conditions re-assert
    always_ff @(posedge clk_i) begin
        if (rst_i | any_reset) begin // R14
            alarm_led_o <= 1'b0;
            fault_led_o <= 1'b0;
            alarm_relay_o <= 1'b0;
            fault_relay_open_o <= 1'b0;
            loop_ma_x10_o <= fds_pkg::MA_NORMAL;
            addr_loop_o <= fds_pkg::AL_NORMAL;
            overlay_alarm_o <= 1'b0;
            overlay_fault_o <= 1'b0;
            overlay_fault_type_o <= 3'h0;
        end else begin
            alarm_led_o <= service_mode_i ? srv_flash : alarm_out;
            fault_led_o <= service_mode_i ? srv_flash : (hw_flash | dirty_flash | cfg_fault); // R02
            alarm_relay_o <= alarm_out;
            fault_relay_open_o <= hw_class | win_dirty_reg; // R05
            loop_ma_x10_o <= loop_ma;
            addr_loop_o <= addr_val;
            overlay_alarm_o <= ctrl_reg[fds_pkg::CTRL_OVERLAY] & alarm_out; // R22
            overlay_fault_o <= ctrl_reg[fds_pkg::CTRL_OVERLAY] & (hw_class | win_dirty_reg | cfg_fault); // R22
            overlay_fault_type_o <= {cfg_fault, win_obsc_reg | win_dirty_reg, hw_fault}; // R22
        end
    end
    assign window_check_start_o = start_reg;
    assign test_lamp_o = test_reg; // R21

    // Read channel: one-cycle answer, unmapped reads give SLVERR
    wire rd_map = (s_axi_araddr == fds_pkg::OFS_CTRL) | (s_axi_araddr == fds_pkg::OFS_STATUS)
        | (s_axi_araddr == fds_pkg::OFS_INTERVAL) | (s_axi_araddr == fds_pkg::OFS_OUTPUTS)
        | (s_axi_araddr == fds_pkg::OFS_CMD);
    wire [31:0] rd_val = (s_axi_araddr == fds_pkg::OFS_CTRL) ? {23'h0, ctrl_reg}
        : (s_axi_araddr == fds_pkg::OFS_STATUS) ? {23'h0, status}
        : (s_axi_araddr == fds_pkg::OFS_INTERVAL) ? {24'h0, interval_reg}
        : (s_axi_araddr == fds_pkg::OFS_OUTPUTS) ? {16'h0, addr_loop_o, loop_ma_x10_o} : 32'h0000_0000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_map ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = ~s_axi_rvalid;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_reset_seen; any_reset; endsequence
    sequence s_blanked; ~alarm_relay_o & ~fault_relay_open_o & ~alarm_led_o; endsequence
    a_nonlatch_fault: assert property (~latching |=> ~hw_latch_reg)
        else $error("fault held in non-latching mode"); // R01
    a_obsc_hw_class: assert property (win_obsc_reg & ~any_reset |=> loop_ma_x10_o == fds_pkg::MA_HW)
        else $error("obscured window not hardware class"); // R02
    a_cfg_fault_heat: assert property (ctrl_reg[fds_pkg::CTRL_HEAT] & ~ctrl_reg[fds_pkg::CTRL_AUX] & ~any_reset
        |=> overlay_fault_type_o[2])
        else $error("heater without aux not flagged"); // R03
    a_service_no_alarm: assert property (service_mode_i |=> ~alarm_reg)
        else $error("alarm during service mode"); // R04
    a_relay_opens: assert property ((hw_class | win_dirty_reg) & ~any_reset |=> fault_relay_open_o)
        else $error("fault relay not open"); // R05
    a_dirty_loop_value: assert property (win_dirty_reg & ~hw_class & ~cont_mode & ~any_reset |=> loop_ma_x10_o == fds_pkg::MA_DIRTY && addr_loop_o == fds_pkg::AL_DIRTY)
        else $error("dirty window loop value wrong"); // R06 R07
    a_confirm_alarm: assert property (tick_reg & confirmed & ~cont_mode & ~any_reset & ~service_mode_i |=> alarm_reg)
        else $error("confirmed alarm not raised"); // R09
    a_reset_blanks: assert property (s_reset_seen |=> s_blanked)
        else $error("outputs not blanked by reset"); // R14
    a_manual_ignored: assert property (man_req & busy_block & wc_idle & ~auto_go & ~rerun_go |=> ~window_check_start_o)
        else $error("manual check taken while busy"); // R15
    a_clean_clears: assert property (done & res_clean |=> ~win_dirty_reg & ~win_obsc_reg)
        else $error("clean result left window fault"); // R20
    a_hw_priority: assert property (hw_class & win_dirty_reg & ~cont_mode & ~any_reset |=> addr_loop_o == fds_pkg::AL_HW)
        else $error("hardware value not preferred"); // R23
endmodule : flame_detector_supervisor
`default_nettype wire

/* fds_pkg.sv */
// Constants of the flame detector supervisor: register map, fields, timing, output codes
package fds_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_INTERVAL = 8'h0C;
    localparam logic [7:0] OFS_OUTPUTS = 8'h10;
    // ==========================================================
    // Control fields
    localparam int CTRL_LATCH = 0;
    localparam int CTRL_CONF = 1;
    localparam int CTRL_AUTO = 3;
    localparam int CTRL_OVERLAY = 4;
    localparam int CTRL_CONT = 5;
    localparam int CTRL_HEAT = 6;
    localparam int CTRL_AUX = 7;
    localparam int CTRL_CFGERR = 8;
    localparam logic [8:0] CTRL_RESET = 9'h018;
    // Command fields (write one to trigger)
    localparam int CMD_RESET = 0;
    localparam int CMD_CHECK = 1;
    localparam int CMD_TEST = 2;
    // Status fields
    localparam int ST_ALARM = 0;
    localparam int ST_PRE = 1;
    localparam int ST_HW = 2;
    localparam int ST_OBSC = 3;
    localparam int ST_DIRTY = 4;
    localparam int ST_CFG = 5;
    localparam int ST_SERVICE = 6;
    localparam int ST_TEST = 7;
    localparam int ST_CHECK = 8;
    localparam logic [7:0] INTERVAL_RESET = 8'h14;
    // ==========================================================
    // Timing
    localparam longint CLK_NS = 10;
    localparam longint SEC_NS = 1000000000;
    localparam int TICK_CYCLES = int'(SEC_NS / CLK_NS);
    localparam int SEC_PER_MIN = 60;
    localparam logic [7:0] OBSC_MIN = 8'h05;
    localparam logic [4:0] DIRTY_RUN = 5'h14;
    localparam logic [4:0] OBSC_RUN = 5'h05;
    localparam logic [3:0] CLEAR_RUN = 4'hA;
    localparam logic [2:0] SERVICE_SEC = 3'h5;
    localparam logic [3:0] TEST_SEC = 4'hE;
    // ==========================================================
    // Window check results
    localparam logic [1:0] WIN_CLEAN = 2'h0;
    localparam logic [1:0] WIN_DIRTY = 2'h1;
    localparam logic [1:0] WIN_OBSC = 2'h2;
    // Current loop in tenths of mA, addressable loop values
    localparam logic [7:0] MA_NORMAL = 8'h28;
    localparam logic [7:0] MA_PRE = 8'h73;
    localparam logic [7:0] MA_ALARM = 8'hAA;
    localparam logic [7:0] MA_HW = 8'h00;
    localparam logic [7:0] MA_DIRTY = 8'h14;
    localparam logic [7:0] AL_NORMAL = 8'h40;
    localparam logic [7:0] AL_PRE = 8'h99;
    localparam logic [7:0] AL_ALARM = 8'hBE;
    localparam logic [7:0] AL_HW = 8'h0A;
    localparam logic [7:0] AL_DIRTY = 8'h1F;
    // Window check sequencer
    typedef enum logic [1:0] {WC_IDLE = 2'b01, WC_BUSY = 2'b10} wc_state_t;
endpackage : fds_pkg

/* window_sensor_model.sv */
// Window check optics model: answers every start pulse with a result after a short delay
`timescale 1ns/100ps
`default_nettype none
module window_sensor_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [1:0] level_i,
    output logic valid_o,
    output logic [1:0] result_o
);
    logic [2:0] wait_reg;
    // ==========================================================
    // Delay line; result toggles while not valid so stale data is never trusted
    always_ff @(posedge clk_i) begin
        valid_o <= !rst_i && (wait_reg == 3'h1);
        result_o <= (wait_reg == 3'h1) ? level_i : ~result_o;
        wait_reg <= rst_i ? 3'h0 : start_i ? 3'h4 : (wait_reg != 3'h0) ? wait_reg - 3'h1 : 3'h0;
    end
endmodule : window_sensor_model
`default_nettype wire

/* flame_detector_supervisor_bench.sv */
// Self-checking bench: register bus, alarm confirmation, fault outputs and window checks
`timescale 1ns/100ps
`default_nettype none
module flame_detector_supervisor_bench;
    logic clk_i = 1'h0, rst_i = 1'h1, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sensor_level_i = 8'h00, loop_ma_x10_o, addr_loop_o;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, window_result_i, rsp, win_level = 2'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, candidate_alarm_i = 1'h0;
    logic pre_alarm_i = 1'h0, hw_fault_i = 1'h0, service_mode_i = 1'h0, wired_reset_i = 1'h0, tool_reset_i = 1'h0;
    logic manual_check_i = 1'h0, self_test_req_i = 1'h0, window_result_valid_i, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, window_check_start_o, test_lamp_o, alarm_led_o, fault_led_o;
    logic alarm_relay_o, fault_relay_open_o, overlay_alarm_o, overlay_fault_o;
    logic [2:0] overlay_fault_type_o;
    int failures = 0, checked = 0;
    // Short tick keeps the one-second sampling affordable
    flame_detector_supervisor #(.TICK_CYCLES(10)) u_flame_detector_supervisor (.*);
    window_sensor_model u_window_sensor_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(window_check_start_o),
        .level_i(win_level), .valid_o(window_result_valid_i), .result_o(window_result_i));
    always #5 clk_i = ~clk_i;
    // ==========================================================
    // Shared tasks; checks land on the falling edge, drives on the rising edge
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_c(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_c
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_i);
        {wired_reset_i, hw_fault_i, manual_check_i} <= m;
        @(posedge clk_i);
        {wired_reset_i, hw_fault_i, manual_check_i} <= 3'h0;
    endtask : pulse
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t = 1'h0, w_t = 1'h0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw_t && w_t)) begin
            @(negedge clk_i);
            aw_t = aw_t | s_axi_awready;
            w_t = w_t | s_axi_wready;
            @(posedge clk_i);
            if (aw_t) s_axi_awvalid <= 1'h0;
            if (w_t) s_axi_wvalid <= 1'h0;
        end
        do @(negedge clk_i); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        @(posedge clk_i);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(negedge clk_i); while (!s_axi_arready);
        @(posedge clk_i);
        s_axi_arvalid <= 1'h0;
        do @(negedge clk_i); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge clk_i);
    endtask : axi_rd
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk(32'({fault_relay_open_o, alarm_relay_o, addr_loop_o, loop_ma_x10_o}), 32'h0000_4028);
        axi_rd(fds_pkg::OFS_CTRL);
        chk(rd, 32'(fds_pkg::CTRL_RESET));
        axi_wr(8'h40, 32'h0000_0001);
        chk(32'(rsp), 32'h0000_0002);
    endtask : t_reset
    task automatic t_alarm();
        axi_wr(fds_pkg::OFS_CTRL, 32'h0000_0010);
        candidate_alarm_i <= 1'h1;
        wait_c(15);
        chk(32'(alarm_relay_o), 32'h0000_0000);
        wait_c(50);
        chk(32'({alarm_led_o, alarm_relay_o, overlay_alarm_o, addr_loop_o, loop_ma_x10_o}), 32'h0007_BEAA);
        @(posedge clk_i);
        candidate_alarm_i <= 1'h0;
        wait_c(60);
        chk(32'(alarm_relay_o), 32'h0000_0001);
        wait_c(110);
        chk(32'({alarm_led_o, alarm_relay_o, loop_ma_x10_o}), 32'h0000_0028);
    endtask : t_alarm
    task automatic t_faults();
        @(posedge clk_i);
        hw_fault_i <= 1'h1;
        wait_c(3);
        chk(32'({overlay_fault_type_o, overlay_fault_o, fault_relay_open_o, addr_loop_o, loop_ma_x10_o}),
            32'h0007_0A00);
        axi_rd(fds_pkg::OFS_STATUS);
        chk(rd & 32'h0000_001C, 32'h0000_0004);
        win_level <= fds_pkg::WIN_DIRTY;
        axi_wr(fds_pkg::OFS_CMD, 32'h0000_0002);
        wait_c(10);
        chk(32'({addr_loop_o, loop_ma_x10_o}), 32'h0000_0A00);
        @(posedge clk_i);
        hw_fault_i <= 1'h0;
        wait_c(3);
        chk(32'({overlay_fault_type_o, overlay_fault_o, fault_relay_open_o, addr_loop_o, loop_ma_x10_o}),
            32'h000B_1F14);
        axi_rd(fds_pkg::OFS_STATUS);
        chk(rd & 32'h0000_001C, 32'h0000_0010);
        win_level <= fds_pkg::WIN_CLEAN;
        axi_wr(fds_pkg::OFS_CMD, 32'h0000_0002);
        wait_c(10);
        chk(32'({fault_relay_open_o, loop_ma_x10_o}), 32'h0000_0028);
    endtask : t_faults
    task automatic t_latch();
        axi_wr(fds_pkg::OFS_CTRL, 32'h0000_0051);
        win_level <= fds_pkg::WIN_OBSC;
        pulse(3'h3);
        wait_c(10);
        chk(32'({fault_relay_open_o, loop_ma_x10_o}), 32'h0000_0100);
        axi_rd(fds_pkg::OFS_STATUS);
        chk(rd & 32'h0000_000C, 32'h0000_000C);
        win_level <= fds_pkg::WIN_CLEAN;
        pulse(3'h4);
        wait_c(20);
        chk(32'({fault_relay_open_o, addr_loop_o, loop_ma_x10_o}), 32'h0000_4028);
    endtask : t_latch
    task automatic test_done();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // Main sequence and watchdog; the whole run needs well under 2000 cycles
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        wait_c(1);
        t_reset();
        t_alarm();
        t_faults();
        t_latch();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        test_done();
    end
endmodule : flame_detector_supervisor_bench
`default_nettype wire
